//--- include/ivm_pkg.sv
// shared constants and carrier types for the interrupt vector mapper
package ivm_pkg;
  localparam int          NUM_SRC      = 48;            // peripheral sources with a level register
  localparam logic [31:0] BASE_RST     = 32'h000f_fc00; // base reset value: number 0 lands at 0x000ffffc
  localparam logic [9:0]  OFS_TOP      = 10'h03fc;      // offset of number 0
  localparam logic [7:0]  NMI_NUM      = 8'h000f;       // non-maskable request number
  localparam logic [4:0]  NMI_LVL      = 5'h0f;         // non-maskable level, hardwired
  localparam logic [7:0]  PERIPH_BASE  = 8'h0010;       // number of source index 0
  localparam logic [7:0]  TRAP_FIRST   = 8'h0050;       // lowest number a trap may select
  localparam int          SHARED_IDX   = 30;            // reload timer 3 / oscillation wait share this index
  localparam int          DELAY_IDX    = 47;            // delayed interrupt source index
  localparam logic [7:0]  RTOS_NUM_A   = 8'h0040;       // reserved for the real-time os
  localparam logic [7:0]  RTOS_NUM_B   = 8'h0041;       // reserved for the real-time os
  localparam logic [4:0]  LVL_OFF      = 5'h1f;         // all-ones level masks a source

  // number, level and fetch address of one granted request
  typedef struct packed {
    logic [7:0]  num;
    logic [4:0]  level;
    logic [31:0] addr;
  } ivm_grant_t;
endpackage : ivm_pkg

//--- src/ivm_vec_calc.sv
// vector fetch address from table base and interrupt number
`timescale 1ns/1ns
module ivm_vec_calc (
  input  wire logic [31:0] base,
  input  wire logic [7:0]  num,
  output logic      [31:0] addr
);
  logic [9:0] offset; // 0x3fc minus four times the number

  // offset walks down one word per number
  always_comb begin
    offset = ivm_pkg::OFS_TOP - {num, 2'b00};
    addr   = base + {22'h00_0000, offset};
  end
endmodule : ivm_vec_calc

//--- src/ivm_top.sv
// interrupt vector mapper: source to number, level and vector address
`timescale 1ns/1ns
module ivm_top #(
  parameter int NUM_SRC = ivm_pkg::NUM_SRC
) (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic                    base_we,
  input  wire logic [31:0]             base_wdata,
  input  wire logic [NUM_SRC-1:0][4:0] source_level_reg,
  input  wire logic [NUM_SRC-1:0]      periph_req,
  input  wire logic                    reload3_req,
  input  wire logic                    osc_wait_req,
  input  wire logic                    delay_req,
  input  wire logic                    nmi_req,
  input  wire logic                    trap_req,
  input  wire logic [7:0]              trap_num,
  output logic                         irq_valid_ff,
  output ivm_pkg::ivm_grant_t          irq_grant_ff,
  output logic                         trap_valid_ff,
  output ivm_pkg::ivm_grant_t          trap_grant_ff,
  output logic                         stop_wake_ff,
  output logic [31:0]                  vector_table_base_reg_ff
);
  // elaboration check: source indices 30 and 47 are fixed
  if (NUM_SRC != ivm_pkg::NUM_SRC) begin : g_bad_num_src
    $error("ivm_top: NUM_SRC must be 48");
  end

  logic [NUM_SRC-1:0] pend;       // merged pending per source
  logic [NUM_SRC-1:0] active;     // pending and not masked by level
  logic               best_found; // some source is active
  logic [5:0]         best_idx;   // index of winning source
  logic [4:0]         best_lvl;   // level of winning source
  logic [7:0]         win_num;    // number presented this cycle
  logic [4:0]         win_lvl;    // level presented this cycle
  logic [31:0]        win_addr;   // address for the winner
  logic [31:0]        trap_addr;  // address for the trap number
  logic               trap_ok;    // trap number within range
  logic [NUM_SRC-1:0][4:0] lvl_seen_ff; // levels of the previous cycle, checks only

  // per-source merge and level mask
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    if (i == ivm_pkg::SHARED_IDX) begin : g_shared
      assign pend[i] = periph_req[i] | reload3_req | osc_wait_req;
    end else if (i == ivm_pkg::DELAY_IDX) begin : g_delay
      assign pend[i] = periph_req[i] | delay_req;
    end else begin : g_plain
      assign pend[i] = periph_req[i];
    end
    assign active[i] = pend[i] && (source_level_reg[i] != ivm_pkg::LVL_OFF);
  end

  // lowest level value wins, lowest index breaks ties
  always_comb begin
    best_found = 1'b0;
    best_idx   = 6'h00;
    best_lvl   = ivm_pkg::LVL_OFF;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (active[i] && (!best_found || source_level_reg[i] < best_lvl)) begin
        best_found = 1'b1;
        best_idx   = 6'(i);
        best_lvl   = source_level_reg[i];
      end
    end
  end

  // number and level of the winner, nmi first
  always_comb begin
    if (nmi_req) begin
      win_num = ivm_pkg::NMI_NUM;
      win_lvl = ivm_pkg::NMI_LVL;
    end else begin
      win_num = ivm_pkg::PERIPH_BASE + {2'b00, best_idx};
      win_lvl = best_lvl;
    end
  end

  assign trap_ok = trap_req && (trap_num >= ivm_pkg::TRAP_FIRST);

  // address for the hardware winner
  ivm_vec_calc u_win_calc (
    .base (vector_table_base_reg_ff),
    .num  (win_num),
    .addr (win_addr)
  );

  // address for the software trap
  ivm_vec_calc u_trap_calc (
    .base (vector_table_base_reg_ff),
    .num  (trap_num),
    .addr (trap_addr)
  );

  // table base: reset default, then software load
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vector_table_base_reg_ff <= ivm_pkg::BASE_RST;
    end else if (base_we) begin
      vector_table_base_reg_ff <= base_wdata;
    end
  end

  // grant to the cpu, refreshed every cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_valid_ff <= 1'b0;
      irq_grant_ff <= '0;
    end else begin
      irq_valid_ff       <= nmi_req || best_found;
      irq_grant_ff.num   <= win_num;
      irq_grant_ff.level <= win_lvl;
      irq_grant_ff.addr  <= win_addr;
    end
  end

  // trap answer, out-of-range numbers ignored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trap_valid_ff <= 1'b0;
      trap_grant_ff <= '0;
    end else begin
      trap_valid_ff <= trap_ok;
      if (trap_ok) begin
        trap_grant_ff.num   <= trap_num;
        trap_grant_ff.level <= ivm_pkg::LVL_OFF;
        trap_grant_ff.addr  <= trap_addr;
      end
    end
  end

  // stop-mode release on nmi or any unmasked pending source
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stop_wake_ff <= 1'b0;
    end else begin
      stop_wake_ff <= nmi_req || (|active);
    end
  end

  // previous-cycle levels, so the granted level is looked up by the granted number
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lvl_seen_ff <= '0;
    end else begin
      lvl_seen_ff <= source_level_reg;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_vec_address: assert property (
    irq_valid_ff |-> irq_grant_ff.addr ==
      $past(vector_table_base_reg_ff) + {22'h00_0000, 10'h03fc - {irq_grant_ff.num, 2'b00}})
    else $error("vector address does not follow base and number");

  chk_nmi_fixed: assert property (
    nmi_req |=> irq_valid_ff && irq_grant_ff.num == 8'h000f && irq_grant_ff.level == 5'h0f)
    else $error("nmi not presented as number 15 level 15");

  chk_trap_range: assert property (
    trap_req |=> (trap_valid_ff == ($past(trap_num) >= 8'h0050)))
    else $error("trap range decision wrong");

  chk_delay_level: assert property (
    (irq_valid_ff && irq_grant_ff.num == 8'h003f) |->
      ($past(pend[47]) && irq_grant_ff.level == $past(source_level_reg[47])))
    else $error("number 63 not from the delayed source");

  chk_shared_src: assert property (
    (!nmi_req && reload3_req && source_level_reg[30] == 5'h00 && active[29:0] == '0) |=>
      irq_grant_ff.num == 8'h002e)
    else $error("reload timer 3 not mapped to 46");

  chk_rtos_free: assert property (
    irq_valid_ff |-> irq_grant_ff.num != 8'h0040 && irq_grant_ff.num != 8'h0041)
    else $error("hardware drove a reserved os number");

  chk_stop_wake: assert property (
    ((|active) || nmi_req) |=> stop_wake_ff)
    else $error("wake not raised for an unmasked request");

  chk_stop_quiet: assert property (
    (!nmi_req && pend == '0) |=> !stop_wake_ff)
    else $error("wake raised with nothing pending");

  chk_grant_level: assert property (
    (irq_valid_ff && irq_grant_ff.num >= 8'h0010) |->
      irq_grant_ff.level == lvl_seen_ff[6'(irq_grant_ff.num - 8'h0010)])
    else $error("granted level does not match the source");

  cov_nmi: cover property (nmi_req ##1 irq_valid_ff);
  cov_trap: cover property (trap_ok ##1 trap_valid_ff);
  cov_shared: cover property (osc_wait_req && !nmi_req ##1 irq_grant_ff.num == 8'h002e);
  cov_delay: cover property (delay_req && !nmi_req ##1 irq_grant_ff.num == 8'h003f);
endmodule : ivm_top

//--- sim/ivm_cpu_model.sv
// cpu core stand-in: takes each presented request with a word-aligned address as one vector fetch
`timescale 1ns/1ns
module ivm_cpu_model (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                irq_valid,
  input  wire ivm_pkg::ivm_grant_t grant,
  output int                       n_fetch_ff
);
  // count fetches; a fetch needs a word-aligned address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      n_fetch_ff <= 0;
    end else if (irq_valid && grant.addr[1:0] == 2'b00) begin
      n_fetch_ff <= n_fetch_ff + 1;
    end
  end
endmodule : ivm_cpu_model

//--- sim/tb_top.sv
// self-checking bench for the interrupt vector mapper
`timescale 1ns/1ns
module tb_top;
  logic                clk = 0, nrst = 0, we = 0, r3 = 0, ow = 0, dly = 0, nmi = 0, trq = 0;
  logic [47:0][4:0]    lvl = '0;            // per-source levels
  logic [47:0]         req = '0;            // pending sources
  logic [31:0]         wdata = '0, base_m;  // base write data, modelled base
  logic [7:0]          tnum = '0;           // trap number
  logic                iv, tv, wk, e_iv, e_tv, e_wk;
  logic [31:0]         base_o;
  ivm_pkg::ivm_grant_t igr, tgr, e_igr, e_tgr;
  int                  fail_count = 0, n_checks = 0, n_exp = 0, n_fetch;
  always #4 clk = ~clk;
  ivm_top dut_u (.clk(clk), .nrst(nrst), .base_we(we), .base_wdata(wdata), .source_level_reg(lvl),
    .periph_req(req), .reload3_req(r3), .osc_wait_req(ow), .delay_req(dly), .nmi_req(nmi),
    .trap_req(trq), .trap_num(tnum), .irq_valid_ff(iv), .irq_grant_ff(igr), .trap_valid_ff(tv),
    .trap_grant_ff(tgr), .stop_wake_ff(wk), .vector_table_base_reg_ff(base_o));
  ivm_cpu_model cpu_u (.clk(clk), .nrst(nrst), .irq_valid(iv), .grant(igr), .n_fetch_ff(n_fetch));
  // compare one value and count
  task automatic chk(string nm, logic [44:0] seen, logic [44:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // vector address of a number under the modelled base
  function automatic logic [31:0] vaddr(int n);
    return base_m + 32'h0000_03fc - 32'(4 * n);
  endfunction : vaddr
  // expected outputs one cycle after the present inputs
  task automatic predict;
    int bi, bl, n;
    bi = -1;
    bl = 31;
    for (int i = 0; i < 48; i++) begin
      if ((req[i] || (i == 30 && (r3 || ow)) || (i == 47 && dly)) && lvl[i] < bl) begin
        bi = i;
        bl = lvl[i];
      end
    end
    e_wk = nmi || bi >= 0;
    e_iv = e_wk;
    n = nmi ? 15 : 16 + bi;
    e_igr = {8'(n), nmi ? 5'h0f : 5'(bl), vaddr(n)};
    e_tv = trq && tnum >= 8'h50;
    if (e_tv) e_tgr = {tnum, 5'h1f, vaddr(tnum)};
    if (we) base_m = wdata;
  endtask : predict
  // outputs against the model
  task automatic compare;
    chk("irq_valid", 45'(iv), 45'(e_iv));
    chk("stop_wake", 45'(wk), 45'(e_wk));
    if (e_iv) chk("irq_grant", igr, e_igr);
    if (e_iv) chk("not_rtos", 45'(igr.num == 8'h40 || igr.num == 8'h41), 45'(0));
    chk("trap_valid", 45'(tv), 45'(e_tv));
    chk("trap_grant", tgr, e_tgr);
    chk("base", 45'(base_o), 45'(base_m));
    if (e_iv) n_exp++;
  endtask : compare
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // watchdog
  initial begin
    #100000;
    fail_count++;
    wrap_up;
  end
  // main sequence: reset, then random and swept traffic
  initial begin
    void'($urandom(10050));
    base_m = 32'h000f_fc00;
    e_tgr = '0;
    repeat (16) @(posedge clk);
    chk("rst_base", 45'(base_o), 45'(32'h000f_fc00));
    chk("rst_valid", 45'({iv, tv, wk}), 45'(0));
    @(negedge clk) nrst = 1;
    for (int k = 0; k < 3000; k++) begin
      @(negedge clk);
      if (k > 0) compare;
      for (int i = 0; i < 48; i++) lvl[i] = ($urandom % 4 == 0) ? 5'h1f : 5'($urandom);
      for (int i = 0; i < 48; i++) req[i] = k < 2990 && $urandom % 8 == 0;
      {r3, ow, dly} = k < 2990 ? 3'($urandom) & 3'($urandom) : 3'h0;
      nmi = k < 2990 && $urandom % 16 == 0;
      trq = k < 256 || $urandom % 4 == 0;
      tnum = k < 256 ? 8'(k) : 8'($urandom);
      we = $urandom % 16 == 0;
      wdata = $urandom & 32'hffff_fffc;
      // directed: shared source at level 0 with sources 0 to 29 cleared, reload then oscillation wait
      if (k < 2990 && k % 50 < 2) begin
        req[29:0] = '0;
        lvl[30] = 5'h00;
        {r3, ow} = (k % 50 == 0) ? 2'b10 : 2'b01;
        nmi = 1'b0;
      end
      predict;
    end
    @(negedge clk);
    compare;
    chk("fetches", 45'(n_fetch), 45'(n_exp));
    wrap_up;
  end
endmodule : tb_top
